/* File: verilog/dht_top.sv */
// Dual half timer: two 16-bit halves, joined 32-bit one-shot/periodic or
// slow clock counter, or two split 16-bit timers with 8-bit prescalers.
// Assumes an APB master on pclk and a slow clock on capture_pin_0.
// Operation
// - Reset sets counters and load registers to all ones, timer idle
// - Reset clears both prescale registers
// - Configuration 0 joins one-shot/periodic, 1 joins slow clock counter
// - Configuration 4 splits into two 16-bit timers
// - Split halves take their modes independently
// - Joined: load A write fills both load halves, low then high
// - Joined: count A read returns half B above half A
// - Joined timer takes one-shot or periodic from half A mode only
// - Joined timer counts down and reloads the cycle after zero
// - One-shot stops and clears its enable; periodic keeps counting
// - Zero sets sticky raw time-out; masked copy raises interrupt
// - Joined time-out triggers ADC only with half A trigger enable
// - Load write while running reaches the counter next cycle
// - Debug stall bit freezes counting during a debugger halt
// - Slow clock counter counts up, starts at one, compares to match
// - Slow pin clock is divided to a one-second tick
// - Count equal to match rolls to zero and keeps counting
// - Match sets raw and masked flags; clear bit drops both
// - Slow clock enable keeps counting through debugger halt
// - Split half counts down with optional 8-bit prescaler
// - Split half at zero reloads count and prescale; one-shot stops
// - Split time-out sets flags, interrupt, trigger when enabled
// - Mode 1 selects one-shot, mode 2 periodic
// - Writing one to a clear bit drops the flag; zero keeps it
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module dht_top
    import dht_pkg::*;
#(
    parameter int unsigned RTC_DIV = DHT_RTC_DIV
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        dbg_halt,
    input  wire logic        capture_pin_0,
    output logic             irq,
    output logic             adc_trigger
);

    logic [2:0]  cfg_q;
    logic [1:0]  mode_a_q;
    logic [1:0]  mode_b_q;
    logic        en_a_q;
    logic        en_b_q;
    logic        stall_a_q;
    logic        stall_b_q;
    logic        clock_counter_enable_q;
    logic        ote_a_q;
    logic        ote_b_q;
    logic [8:0]  imr_q;
    logic [8:0]  ris_q;
    logic [8:0]  ris_d;
    logic [15:0] load_a_q;
    logic [15:0] load_b_q;
    logic [31:0] match_q;
    logic [7:0]  psr_a_q;
    logic [7:0]  psr_b_q;
    logic [7:0]  psc_a_q;
    logic [7:0]  psc_b_q;
    logic [15:0] cnt_a_q;
    logic [15:0] cnt_b_q;

    function automatic logic is_timer(input logic [1:0] m);
        is_timer = (m == DHT_MODE_ONESHOT) || (m == DHT_MODE_PERIODIC);
    endfunction

    function automatic logic [31:0] fit16(input logic [15:0] v);
        fit16 = {16'h0000, v};
    endfunction

    // Bus decode
    logic setup;
    logic wr;
    logic hit;
    logic [31:0] rdata;

    assign setup = psel & ~penable;
    assign wr    = psel & penable & pready & pwrite;

    logic wr_cfg;
    logic wr_ctl;
    logic wr_load_a;
    logic wr_load_b;
    logic wr_icr;

    assign wr_cfg    = wr && (paddr == DHT_OFS_CFG);
    assign wr_ctl    = wr && (paddr == DHT_OFS_CTL);
    assign wr_load_a = wr && (paddr == DHT_OFS_LOAD_A);
    assign wr_load_b = wr && (paddr == DHT_OFS_LOAD_B);
    assign wr_icr    = wr && (paddr == DHT_OFS_ICR);

    logic joined;
    logic rtc;
    logic split;
    logic [31:0] cnt32;
    logic [31:0] load32;

    assign joined = (cfg_q == DHT_CFG_JOIN);
    assign rtc    = (cfg_q == DHT_CFG_RTC);
    assign split  = (cfg_q == DHT_CFG_SPLIT);
    assign cnt32  = {cnt_b_q, cnt_a_q};
    assign load32 = {load_b_q, load_a_q};

    // Stall and run qualifiers
    logic stall_a;
    logic stall_b;
    logic stall_rtc;
    logic run_a;
    logic run_b;
    logic tick;

    assign stall_a   = dbg_halt & stall_a_q;
    assign stall_b   = dbg_halt & stall_b_q;
    assign stall_rtc = dbg_halt & (stall_a_q | stall_b_q) & ~clock_counter_enable_q;
    // Joined timer ignores half B mode; split halves use their own
    assign run_a = en_a_q & is_timer(mode_a_q) & ~stall_a & (joined | split);
    assign run_b = en_b_q & is_timer(mode_b_q) & ~stall_b & split;

    dht_rtc_div #(
        .DIV (RTC_DIV)
    ) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .slow_in (capture_pin_0),
        .clear   (~(rtc & en_a_q)),
        .hold    (stall_rtc),
        .tick    (tick)
    );

    // Events of this cycle
    logic tmo_a;
    logic tmo_b;
    logic rtc_match;
    logic rtc_step;

    assign tmo_a = run_a && (joined ? (cnt32 == 32'h0000_0000)
                                    : (cnt_a_q == 16'h0000 && psc_a_q == 8'h00));
    assign tmo_b = run_b && (cnt_b_q == 16'h0000) && (psc_b_q == 8'h00);
    assign rtc_step  = rtc & en_a_q & ~stall_rtc & tick;
    assign rtc_match = rtc_step && (cnt32 == match_q);

    // Configuration, modes, mask, match, prescale registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q    <= DHT_RST_CFG;
            mode_a_q <= 2'h0;
            mode_b_q <= 2'h0;
            imr_q    <= 9'h000;
            match_q  <= DHT_RST_MATCH;
            psr_a_q  <= DHT_RST_PSC;
            psr_b_q  <= DHT_RST_PSC;
        end else if (wr) begin
            case (paddr)
                DHT_OFS_CFG:    cfg_q    <= pwdata[2:0];
                DHT_OFS_MODE_A: mode_a_q <= pwdata[1:0];
                DHT_OFS_MODE_B: mode_b_q <= pwdata[1:0];
                DHT_OFS_IMR:    imr_q    <= pwdata[8:0];
                DHT_OFS_MATCH:  match_q  <= pwdata;
                DHT_OFS_PSC_A:  psr_a_q  <= pwdata[7:0];
                DHT_OFS_PSC_B:  psr_b_q  <= pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // Load registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_a_q <= DHT_RST_LOAD;
            load_b_q <= DHT_RST_LOAD;
        end else begin
            if (wr_load_a) begin
                load_a_q <= pwdata[15:0];
                if (!split) begin
                    load_b_q <= pwdata[31:16];
                end
            end else if (wr_load_b) begin
                load_b_q <= pwdata[15:0];
            end
        end
    end

    // Control register; a software write beats a one-shot self-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_a_q    <= 1'b0;
            en_b_q    <= 1'b0;
            stall_a_q <= 1'b0;
            stall_b_q <= 1'b0;
            clock_counter_enable_q   <= 1'b0;
            ote_a_q   <= 1'b0;
            ote_b_q   <= 1'b0;
        end else if (wr_ctl) begin
            en_a_q    <= pwdata[DHT_CTL_EN_A];
            en_b_q    <= pwdata[DHT_CTL_EN_B];
            stall_a_q <= pwdata[DHT_CTL_STALL_A];
            stall_b_q <= pwdata[DHT_CTL_STALL_B];
            clock_counter_enable_q   <= pwdata[DHT_CTL_CLOCK_COUNTER_ENABLE];
            ote_a_q   <= pwdata[DHT_CTL_OTE_A];
            ote_b_q   <= pwdata[DHT_CTL_OTE_B];
        end else begin
            if (tmo_a && mode_a_q == DHT_MODE_ONESHOT) begin
                en_a_q <= 1'b0;
            end
            if (tmo_b && mode_b_q == DHT_MODE_ONESHOT) begin
                en_b_q <= 1'b0;
            end
        end
    end

    // Counters and prescale counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_a_q <= DHT_RST_CNT;
            cnt_b_q <= DHT_RST_CNT;
            psc_a_q <= DHT_RST_PSC;
            psc_b_q <= DHT_RST_PSC;
        end else if (wr_cfg && pwdata[2:0] == DHT_CFG_RTC && !rtc) begin
            {cnt_b_q, cnt_a_q} <= DHT_RTC_START;
        end else if (joined) begin
            if (wr_load_a) begin
                {cnt_b_q, cnt_a_q} <= pwdata;
            end else if (tmo_a) begin
                {cnt_b_q, cnt_a_q} <= load32;
            end else if (run_a) begin
                {cnt_b_q, cnt_a_q} <= cnt32 - 32'h0000_0001;
            end
        end else if (rtc) begin
            if (rtc_match) begin
                {cnt_b_q, cnt_a_q} <= 32'h0000_0000;
            end else if (rtc_step) begin
                {cnt_b_q, cnt_a_q} <= cnt32 + 32'h0000_0001;
            end
        end else if (split) begin
            if (wr_load_a) begin
                cnt_a_q <= pwdata[15:0];
                psc_a_q <= psr_a_q;
            end else if (tmo_a) begin
                cnt_a_q <= load_a_q;
                psc_a_q <= psr_a_q;
            end else if (run_a) begin
                if (psc_a_q == 8'h00) begin
                    cnt_a_q <= cnt_a_q - 16'h0001;
                    psc_a_q <= psr_a_q;
                end else begin
                    psc_a_q <= psc_a_q - 8'h01;
                end
            end
            if (wr_load_b) begin
                cnt_b_q <= pwdata[15:0];
                psc_b_q <= psr_b_q;
            end else if (tmo_b) begin
                cnt_b_q <= load_b_q;
                psc_b_q <= psr_b_q;
            end else if (run_b) begin
                if (psc_b_q == 8'h00) begin
                    cnt_b_q <= cnt_b_q - 16'h0001;
                    psc_b_q <= psr_b_q;
                end else begin
                    psc_b_q <= psc_b_q - 8'h01;
                end
            end
        end
    end

    // Sticky flags: an event in the clearing cycle survives
    logic [8:0] set_vec;
    logic [8:0] clr_vec;

    always_comb begin
        set_vec = 9'h000;
        set_vec[DHT_FLG_TMO_A] = tmo_a;
        set_vec[DHT_FLG_RTC]   = rtc_match;
        set_vec[DHT_FLG_TMO_B] = tmo_b;
        clr_vec = wr_icr ? pwdata[8:0] : 9'h000;
        ris_d   = (ris_q & ~clr_vec) | set_vec;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ris_q       <= 9'h000;
            irq         <= 1'b0;
            adc_trigger <= 1'b0;
        end else begin
            ris_q       <= ris_d;
            irq         <= |(ris_d & imr_q);
            adc_trigger <= (tmo_a & ote_a_q) | (tmo_b & ote_b_q);
        end
    end

    // Read mux
    always_comb begin
        hit   = 1'b1;
        rdata = 32'h0000_0000;
        case (paddr)
            DHT_OFS_CFG:    rdata = {29'h0000_0000, cfg_q};
            DHT_OFS_MODE_A: rdata = {30'h0000_0000, mode_a_q};
            DHT_OFS_MODE_B: rdata = {30'h0000_0000, mode_b_q};
            DHT_OFS_CTL: begin
                rdata[DHT_CTL_EN_A]    = en_a_q;
                rdata[DHT_CTL_STALL_A] = stall_a_q;
                rdata[DHT_CTL_CLOCK_COUNTER_ENABLE]   = clock_counter_enable_q;
                rdata[DHT_CTL_OTE_A]   = ote_a_q;
                rdata[DHT_CTL_EN_B]    = en_b_q;
                rdata[DHT_CTL_STALL_B] = stall_b_q;
                rdata[DHT_CTL_OTE_B]   = ote_b_q;
            end
            DHT_OFS_IMR:    rdata = {23'h00_0000, imr_q};
            DHT_OFS_RIS:    rdata = {23'h00_0000, ris_q};
            DHT_OFS_MIS:    rdata = {23'h00_0000, ris_q & imr_q};
            DHT_OFS_ICR:    rdata = 32'h0000_0000;
            DHT_OFS_LOAD_A: rdata = split ? fit16(load_a_q) : load32;
            DHT_OFS_LOAD_B: rdata = fit16(load_b_q);
            DHT_OFS_MATCH:  rdata = split ? fit16(match_q[15:0]) : match_q;
            DHT_OFS_PSC_A:  rdata = {24'h00_0000, psr_a_q};
            DHT_OFS_PSC_B:  rdata = {24'h00_0000, psr_b_q};
            DHT_OFS_CNT_A:  rdata = split ? fit16(cnt_a_q) : cnt32;
            DHT_OFS_CNT_B:  rdata = fit16(cnt_b_q);
            default:        hit   = 1'b0;
        endcase
    end

    // Read data captured in setup; one access cycle per transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata  <= (pwrite || !hit) ? 32'h0000_0000 : rdata;
                pslverr <= ~hit;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_reset_vals;
        !$past(presetn) |-> cnt32 == 32'hFFFF_FFFF && load32 == 32'hFFFF_FFFF && !en_a_q;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

    property p_reset_psc;
        !$past(presetn) |-> psr_a_q == 8'h00 && psr_b_q == 8'h00;
    endproperty
    a_reset_psc: assert property (p_reset_psc) else $error("prescale not zero");

    property p_join_load;
        wr_load_a && joined |=> load_a_q == $past(pwdata[15:0])
                               && load_b_q == $past(pwdata[31:16]);
    endproperty
    a_join_load: assert property (p_join_load) else $error("joined load split wrong");

    property p_count_down;
        joined && run_a && cnt32 != 32'h0000_0000 && !wr_load_a && !wr_cfg
            |=> cnt32 == $past(cnt32) - 32'h0000_0001;
    endproperty
    a_count_down: assert property (p_count_down) else $error("joined count not down");

    // Split B may still run, so only half A must hold there
    property p_oneshot_stop;
        tmo_a && mode_a_q == DHT_MODE_ONESHOT && !wr_ctl
            |=> !en_a_q ##1 $stable(cnt_a_q) && (split || $stable(cnt_b_q));
    endproperty
    a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot kept running");

    property p_tmo_flag;
        tmo_a |=> ris_q[DHT_FLG_TMO_A] && (irq == imr_q[DHT_FLG_TMO_A] || irq);
    endproperty
    a_tmo_flag: assert property (p_tmo_flag) else $error("time-out flag missing");

    property p_trigger;
        adc_trigger |-> $past((tmo_a && ote_a_q) || (tmo_b && ote_b_q));
    endproperty
    a_trigger: assert property (p_trigger) else $error("stray trigger");

    property p_stall;
        joined && en_a_q && stall_a && !wr_load_a && !wr_cfg |=> $stable(cnt32);
    endproperty
    a_stall: assert property (p_stall) else $error("count moved in halt");

    property p_rollover;
        rtc_match && !wr_cfg |=> cnt32 == 32'h0000_0000 && ris_q[DHT_FLG_RTC];
    endproperty
    a_rollover: assert property (p_rollover) else $error("no rollover at match");

    property p_split_reload;
        split && tmo_b && !wr_load_b && !wr_cfg
            |=> cnt_b_q == $past(load_b_q) && psc_b_q == $past(psr_b_q);
    endproperty
    a_split_reload: assert property (p_split_reload) else $error("split reload wrong");

    property p_prescale_hold;
        split && run_a && psc_a_q != 8'h00 && !wr_load_a && !wr_cfg |=> $stable(cnt_a_q);
    endproperty
    a_prescale_hold: assert property (p_prescale_hold) else $error("prescale ignored");

    property p_clear;
        wr_icr && pwdata[DHT_FLG_TMO_B] && !tmo_b |=> !ris_q[DHT_FLG_TMO_B];
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");

    property p_cv_periodic;
        tmo_a && mode_a_q == DHT_MODE_PERIODIC;
    endproperty
    c_periodic: cover property (p_cv_periodic);

    property p_cv_rtc;
        rtc_match;
    endproperty
    c_rtc: cover property (p_cv_rtc);

    property p_cv_split;
        tmo_a && tmo_b && split;
    endproperty
    c_split: cover property (p_cv_split);

endmodule
`default_nettype wire

/* File: verilog/dht_pkg.sv */
// Constants shared by the dual half timer: register map, field layout,
// reset values, configuration and mode codes, divider figures.
// Assumes a 32-bit APB slave with byte addresses on paddr[11:0].
package dht_pkg;

    localparam logic [11:0] DHT_OFS_CFG    = 12'h000;
    localparam logic [11:0] DHT_OFS_MODE_A = 12'h004;
    localparam logic [11:0] DHT_OFS_MODE_B = 12'h008;
    localparam logic [11:0] DHT_OFS_CTL    = 12'h00C;
    localparam logic [11:0] DHT_OFS_IMR    = 12'h018;
    localparam logic [11:0] DHT_OFS_RIS    = 12'h01C;
    localparam logic [11:0] DHT_OFS_MIS    = 12'h020;
    localparam logic [11:0] DHT_OFS_ICR    = 12'h024;
    localparam logic [11:0] DHT_OFS_LOAD_A = 12'h028;
    localparam logic [11:0] DHT_OFS_LOAD_B = 12'h02C;
    localparam logic [11:0] DHT_OFS_MATCH  = 12'h030;
    localparam logic [11:0] DHT_OFS_PSC_A  = 12'h038;
    localparam logic [11:0] DHT_OFS_PSC_B  = 12'h03C;
    localparam logic [11:0] DHT_OFS_CNT_A  = 12'h048;
    localparam logic [11:0] DHT_OFS_CNT_B  = 12'h04C;

    // Control register bit positions
    localparam int DHT_CTL_EN_A    = 0;
    localparam int DHT_CTL_STALL_A = 1;
    localparam int DHT_CTL_CLOCK_COUNTER_ENABLE   = 4;
    localparam int DHT_CTL_OTE_A   = 5;
    localparam int DHT_CTL_EN_B    = 8;
    localparam int DHT_CTL_STALL_B = 9;
    localparam int DHT_CTL_OTE_B   = 13;

    // Status, mask and clear bit positions
    localparam int DHT_FLG_TMO_A = 0;
    localparam int DHT_FLG_RTC   = 3;
    localparam int DHT_FLG_TMO_B = 8;
    localparam int DHT_FLG_W     = 9;

    localparam logic [2:0] DHT_CFG_JOIN  = 3'h0;
    localparam logic [2:0] DHT_CFG_RTC   = 3'h1;
    localparam logic [2:0] DHT_CFG_SPLIT = 3'h4;

    localparam logic [1:0] DHT_MODE_ONESHOT  = 2'h1;
    localparam logic [1:0] DHT_MODE_PERIODIC = 2'h2;

    localparam logic [15:0] DHT_RST_CNT  = 16'hFFFF;
    localparam logic [15:0] DHT_RST_LOAD = 16'hFFFF;
    localparam logic [7:0]  DHT_RST_PSC  = 8'h00;
    localparam logic [2:0]  DHT_RST_CFG  = 3'h0;
    localparam logic [31:0] DHT_RST_MATCH = 32'hFFFF_FFFF;
    localparam logic [31:0] DHT_RTC_START = 32'h0000_0001;

    // Slow clock figures; edges per tick derived from them
    localparam int DHT_RTC_IN_HZ = 32768;
    localparam int DHT_TICK_HZ   = 1;
    localparam int DHT_RTC_DIV   = DHT_RTC_IN_HZ / DHT_TICK_HZ;

endpackage

/* File: verilog/dht_rtc_div.sv */
// Slow clock divider: synchronises the capture pin, counts its rising
// edges and pulses a one-cycle tick every DIV edges.
// Assumes the pin is far slower than pclk.
`timescale 1ns/10ps
`default_nettype none
module dht_rtc_div
    import dht_pkg::*;
#(
    parameter int unsigned DIV = DHT_RTC_DIV
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic slow_in,
    input  wire logic clear,
    input  wire logic hold,
    output logic      tick
);

    logic        sync1_q;
    logic        sync2_q;
    logic        prev_q;
    logic [15:0] edges_q;
    logic        rise;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end else begin
            sync1_q <= slow_in;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign rise = sync2_q & ~prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edges_q <= 16'h0000;
            tick    <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (clear) begin
                edges_q <= 16'h0000;
            end else if (rise && !hold) begin
                if (edges_q == 16'(DIV - 1)) begin
                    edges_q <= 16'h0000;
                    tick    <= 1'b1;
                end else begin
                    edges_q <= edges_q + 16'h0001;
                end
            end
        end
    end

endmodule
`default_nettype wire

/* File: bench/tb_dht_top.sv */
// Self-checking bench for the dual half timer over APB.
// Assumes dht_pkg and dht_top are compiled first; slow clock divider set to 4.
`timescale 1ns/10ps
`default_nettype none
module tb_dht_top import dht_pkg::*;;
    logic        pclk          = 1'b0;
    logic        presetn       = 1'b0;
    logic        psel          = 1'b0;
    logic        penable       = 1'b0;
    logic        pwrite        = 1'b0;
    logic [11:0] paddr         = 12'h000;
    logic [31:0] pwdata        = 32'h0000_0000;
    logic        dbg_halt      = 1'b0;
    logic        capture_pin_0 = 1'b0;
    logic        slow_run      = 1'b0;
    logic [2:0]  slow_div      = 3'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        adc_trigger;
    logic        last_err;
    logic [31:0] rd_q;
    int          mismatches    = 0;
    int          tests_run     = 0;

    dht_top #(.RTC_DIV(4)) dht_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dbg_halt(dbg_halt),
        .capture_pin_0(capture_pin_0), .irq(irq), .adc_trigger(adc_trigger));

    always #5 pclk = ~pclk;

    // Slow pin stands still unless the slow counter is under test
    always @(posedge pclk) begin
        slow_div <= slow_div + 3'h1;
        if (slow_run && slow_div == 3'h7) begin
            capture_pin_0 <= ~capture_pin_0;
        end
    end

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic hang();
        chk(32'h0000_0000, 32'h0000_0001);
        end_sim();
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) hang();
        rd_q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd_q, exp);
    endtask

    // Cycles from the call to the next trigger pulse
    task automatic wait_trig(output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (adc_trigger !== 1'b1 && n < 2000);
        if (adc_trigger !== 1'b1) hang();
    endtask

    task automatic t_reset();
        rd(DHT_OFS_LOAD_A, 32'hFFFF_FFFF);
        rd(DHT_OFS_CNT_A, 32'hFFFF_FFFF);
        rd(DHT_OFS_PSC_A, 32'h0000_0000);
        rd(DHT_OFS_PSC_B, 32'h0000_0000);
        rd(DHT_OFS_CTL, 32'h0000_0000);
        rd(12'h100, 32'h0000_0000);
        chk({31'h0, last_err}, 32'h0000_0001);
    endtask

    task automatic t_oneshot();
        int n;
        wr(DHT_OFS_CFG, {29'h0, DHT_CFG_JOIN});
        wr(DHT_OFS_MODE_A, {30'h0, DHT_MODE_ONESHOT});
        wr(DHT_OFS_MODE_B, {30'h0, DHT_MODE_PERIODIC});
        wr(DHT_OFS_LOAD_A, 32'h0003_0010);
        rd(DHT_OFS_LOAD_B, 32'h0000_0003);
        wr(DHT_OFS_LOAD_A, 32'h0000_0010);
        wr(DHT_OFS_IMR, 32'h0000_0001);
        wr(DHT_OFS_CTL, 32'h0000_0021);
        wait_trig(n);
        // Sixteen downs, the zero cycle, the trigger flop, then the look
        chk(32'(n), 32'h0000_0012);
        rd(DHT_OFS_CTL, 32'h0000_0020);
        chk({31'h0, irq}, 32'h0000_0001);
        rd(DHT_OFS_CNT_A, 32'h0000_0010);
        rd(DHT_OFS_MIS, 32'h0000_0001);
        wr(DHT_OFS_ICR, 32'h0000_0000);
        rd(DHT_OFS_RIS, 32'h0000_0001);
        wr(DHT_OFS_ICR, 32'h0000_0001);
        rd(DHT_OFS_RIS, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
    endtask

    task automatic t_periodic();
        int n;
        wr(DHT_OFS_MODE_A, {30'h0, DHT_MODE_PERIODIC});
        wr(DHT_OFS_LOAD_A, 32'h0000_0100);
        wr(DHT_OFS_CTL, 32'h0000_0023);
        wr(DHT_OFS_LOAD_A, 32'h0000_0008);
        wait_trig(n);
        chk(32'(n < 16), 32'h0000_0001);
        wait_trig(n);
        chk(32'(n), 32'h0000_0009);
        dbg_halt <= 1'b1;
        apb(1'b0, DHT_OFS_CNT_A, 32'h0000_0000);
        rd(DHT_OFS_CNT_A, rd_q);
        dbg_halt <= 1'b0;
        wait_trig(n);
        wr(DHT_OFS_CTL, 32'h0000_0001);
        n = 0;
        repeat (30) begin
            @(posedge pclk);
            n += int'(adc_trigger === 1'b1);
        end
        chk(32'(n), 32'h0000_0000);
        rd(DHT_OFS_RIS, 32'h0000_0001);
        wr(DHT_OFS_CTL, 32'h0000_0000);
        wr(DHT_OFS_ICR, 32'h0000_0001);
    endtask

    task automatic t_split();
        int n;
        wr(DHT_OFS_CFG, {29'h0, DHT_CFG_SPLIT});
        wr(DHT_OFS_MODE_A, {30'h0, DHT_MODE_ONESHOT});
        wr(DHT_OFS_MODE_B, {30'h0, DHT_MODE_PERIODIC});
        // Prescale before load: the load write reseeds the prescale counter
        wr(DHT_OFS_PSC_A, 32'h0000_0002);
        wr(DHT_OFS_PSC_B, 32'h0000_0001);
        wr(DHT_OFS_LOAD_A, 32'h0000_0003);
        wr(DHT_OFS_LOAD_B, 32'h0000_0005);
        wr(DHT_OFS_IMR, 32'h0000_0100);
        wr(DHT_OFS_CTL, 32'h0000_2101);
        wait_trig(n);
        wait_trig(n);
        chk(32'(n), 32'h0000_000C);
        rd(DHT_OFS_CTL, 32'h0000_2100);
        rd(DHT_OFS_RIS, 32'h0000_0101);
        rd(DHT_OFS_MIS, 32'h0000_0100);
        rd(DHT_OFS_PSC_B, 32'h0000_0001);
        wr(DHT_OFS_CTL, 32'h0000_0000);
        wr(DHT_OFS_ICR, 32'h0000_0109);
    endtask

    task automatic t_rtc();
        int n;
        wr(DHT_OFS_CFG, {29'h0, DHT_CFG_RTC});
        rd(DHT_OFS_CNT_A, 32'h0000_0001);
        wr(DHT_OFS_MATCH, 32'h0000_0002);
        wr(DHT_OFS_IMR, 32'h0000_0008);
        dbg_halt <= 1'b1;
        wr(DHT_OFS_CTL, 32'h0000_0013);
        slow_run <= 1'b1;
        n = 0;
        while (irq !== 1'b1 && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        if (irq !== 1'b1) hang();
        // Ticks of 64 clocks: one from one up to match, one to roll over
        chk(32'(n >= 110 && n <= 130), 32'h0000_0001);
        rd(DHT_OFS_MIS, 32'h0000_0008);
        rd(DHT_OFS_CNT_A, 32'h0000_0000);
        n = 0;
        do begin
            apb(1'b0, DHT_OFS_CNT_A, 32'h0000_0000);
            n++;
        end while (rd_q === 32'h0000_0000 && n < 40);
        chk(rd_q, 32'h0000_0001);
        wr(DHT_OFS_ICR, 32'h0000_0008);
        rd(DHT_OFS_RIS, 32'h0000_0000);
        slow_run <= 1'b0;
        dbg_halt <= 1'b0;
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_oneshot();
        t_periodic();
        t_split();
        t_rtc();
        end_sim();
    end
endmodule
`default_nettype wire
